// >>> rtl/bocd_pkg.sv
// bocd_pkg: opcode patterns, field positions and widths for the bit/call decoder
// assumes a 14-bit instruction word and a 13-bit program counter
package bocd_pkg;
	// ----------------------------------------
	// word and field layout
	// ----------------------------------------
	localparam int OPW = 14;
	localparam int PCW = 13;
	localparam int FADDR_W = 7;
	localparam int BIDX_LSB = 7;
	localparam int BIDX_W = 3;
	localparam int CALL_K_W = 11;
	localparam int LATCH_HI = 4;
	localparam int LATCH_LO = 3;
	// ----------------------------------------
	// opcode patterns
	// ----------------------------------------
	localparam logic [3:0] OP_BIT_CLEAR = 4'h4;
	localparam logic [3:0] OP_BIT_SET = 4'h5;
	localparam logic [3:0] OP_SKIP_ZERO = 4'h6;
	localparam logic [3:0] OP_SKIP_ONE = 4'h7;
	localparam logic [2:0] OP_CALL = 3'h4;
	localparam logic [PCW-1:0] PC_RESET = 13'h0000;
	localparam logic [OPW-1:0] NOP_WORD = 14'h0000;
	typedef enum logic [1:0] {BOCD_RUN, BOCD_FLUSH, BOCD_CALL2} bocd_state_e;
endpackage

// >>> rtl/bocd_bit_alu.sv
// bocd_bit_alu: single-bit modify and test of one file register byte
// assumes pure combinational use inside the decoder
`timescale 1ns/100ps
module bocd_bit_alu
	import bocd_pkg::*;
(
	input wire logic [7:0] data_in,
	input wire logic [BIDX_W-1:0] bit_idx_in,
	input wire logic set_in,
	output logic [7:0] data_out,
	output logic bit_out
);
	wire [7:0] mask = 8'h01 << bit_idx_in;
	assign data_out = set_in ? (data_in | mask) : (data_in & ~mask);
	assign bit_out = |(data_in & mask);
endmodule

// >>> rtl/bocd_core.sv
// bocd_core: executes bit clear, bit set, bit test skip and call
// assumes a file register port answering reads in the same cycle,
// and a return stack that takes a push strobe with its data
// Notes on behaviour
// - 0100bbbfffffff clears bit b of f
// - 0101bbbfffffff sets bit b of f
// - 0110 pattern skips next when bit zero
// - taken skip discards prefetch, runs nop
// - 0111 pattern skips next when bit one
// - f is low seven bits, b next three
// - call pushes pc plus one to stack
// - call loads k into pc, latch bits high
// - 100k pattern is call, two cycles
`timescale 1ns/100ps
module bocd_core
	import bocd_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic [OPW-1:0] instr_in,
	input wire logic [7:0] file_rdata_in,
	input wire logic [7:0] pc_high_latch_in,
	output logic [FADDR_W-1:0] file_addr_out,
	output logic [7:0] file_wdata_out,
	output logic file_we_out,
	output logic [PCW-1:0] pc_out,
	output logic stack_push_out,
	output logic [PCW-1:0] stack_top_out,
	output logic status_we_out,
	output logic busy_out
);
	// ----------------------------------------
	// decode
	// ----------------------------------------
	bocd_state_e state;
	bocd_state_e next_state;
	logic [PCW-1:0] next_pc;
	logic [PCW-1:0] pc;
	logic [PCW-1:0] push_val;
	logic push;
	// shared by the pc step and the pushed return address
	function automatic logic [PCW-1:0] pc_plus_one(input logic [PCW-1:0] v);
		pc_plus_one = v + 13'h0001;
	endfunction
	wire run = (state == BOCD_RUN);
	// the word executed in a flush cycle is forced to a nop
	wire [OPW-1:0] word = run ? instr_in : NOP_WORD;
	wire [3:0] top4 = word[OPW-1:OPW-4];
	wire bit_clear_op = top4 == OP_BIT_CLEAR;
	wire bit_set_op = top4 == OP_BIT_SET;
	wire test_skip_if_zero_op = top4 == OP_SKIP_ZERO;
	wire test_skip_if_one_op = top4 == OP_SKIP_ONE;
	wire call_op = word[OPW-1:OPW-3] == OP_CALL;
	wire [BIDX_W-1:0] bit_idx = word[BIDX_LSB+BIDX_W-1:BIDX_LSB];
	wire [7:0] modified;
	wire sel_bit;
	bocd_bit_alu bocd_bit_alu_i (
		.data_in(file_rdata_in),
		.bit_idx_in(bit_idx),
		.set_in(bit_set_op),
		.data_out(modified),
		.bit_out(sel_bit)
	);
	wire skip = (test_skip_if_zero_op & ~sel_bit) | (test_skip_if_one_op & sel_bit);
	wire [PCW-1:0] call_target = {pc_high_latch_in[LATCH_HI:LATCH_LO],
		word[CALL_K_W-1:0]};
	assign file_addr_out = word[FADDR_W-1:0];
	// read-modify-write in a single cycle; status flags untouched
	// no register write may leak out while the core is held in reset
	assign file_we_out = reset_n_in & (bit_clear_op | bit_set_op);
	assign file_wdata_out = modified;
	assign status_we_out = 1'b0;
	assign busy_out = ~run;
	// ----------------------------------------
	// sequencing
	// ----------------------------------------
	always_comb begin
		next_state = BOCD_RUN;
		next_pc = pc_plus_one(pc);
		push = 1'b0;
		push_val = pc_plus_one(pc);
		case (state)
			BOCD_RUN: begin
				if (call_op) begin
					push = 1'b1;
					next_pc = call_target;
					next_state = BOCD_CALL2;
				end else if (skip) begin
					next_state = BOCD_FLUSH;
				end
			end
			BOCD_FLUSH: next_state = BOCD_RUN;
			// second call cycle refetches from the new target
			BOCD_CALL2: next_pc = pc;
			default: next_state = BOCD_RUN;
		endcase
	end
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state <= BOCD_RUN;
			pc <= PC_RESET;
			stack_push_out <= 1'b0;
			stack_top_out <= PC_RESET;
		end else begin
			state <= next_state;
			pc <= next_pc;
			stack_push_out <= push;
			if (push) begin
				stack_top_out <= push_val;
			end
		end
	end
	assign pc_out = pc;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_skip_taken;
		run && skip && !call_op;
	endsequence
	sequence s_call_taken;
		run && call_op;
	endsequence
	// one discarded cycle, then back to normal execution
	sequence s_one_nop;
		busy_out ##1 !busy_out;
	endsequence
	property p_flush;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_skip_taken |=> s_one_nop;
	endproperty
	a_flush: assert property (p_flush) else $error("skip not two cycles");
	// the fetched word must neither write nor push while it is discarded
	property p_flush_quiet;
		@(posedge clk_in) disable iff (!reset_n_in)
		busy_out |-> !file_we_out ##1 !stack_push_out;
	endproperty
	a_flush_quiet: assert property (p_flush_quiet) else $error("discarded word acted");
	property p_clear;
		@(posedge clk_in) disable iff (!reset_n_in)
		bit_clear_op |-> file_we_out && !file_wdata_out[bit_idx];
	endproperty
	a_clear: assert property (p_clear) else $error("bit clear wrong");
	property p_set;
		@(posedge clk_in) disable iff (!reset_n_in)
		bit_set_op |-> file_we_out && file_wdata_out[bit_idx];
	endproperty
	a_set: assert property (p_set) else $error("bit set wrong");
	// the mask compare covers every untouched bit, not only bit b
	property p_keep_clear;
		@(posedge clk_in) disable iff (!reset_n_in)
		bit_clear_op |-> ((file_wdata_out ^ file_rdata_in) & ~(8'h01 << bit_idx)) == 8'h00;
	endproperty
	a_keep_clear: assert property (p_keep_clear) else $error("clear hit other bits");
	property p_keep_set;
		@(posedge clk_in) disable iff (!reset_n_in)
		bit_set_op |-> ((file_wdata_out ^ file_rdata_in) & ~(8'h01 << bit_idx)) == 8'h00;
	endproperty
	a_keep_set: assert property (p_keep_set) else $error("set hit other bits");
	property p_zero;
		@(posedge clk_in) disable iff (!reset_n_in)
		run && test_skip_if_zero_op && !file_rdata_in[bit_idx] |=> state == BOCD_FLUSH;
	endproperty
	a_zero: assert property (p_zero) else $error("skip on zero missed");
	property p_stay_zero;
		@(posedge clk_in) disable iff (!reset_n_in)
		run && test_skip_if_zero_op && file_rdata_in[bit_idx] |=> !busy_out;
	endproperty
	a_stay_zero: assert property (p_stay_zero) else $error("skip on zero taken wrongly");
	property p_one;
		@(posedge clk_in) disable iff (!reset_n_in)
		run && test_skip_if_one_op && file_rdata_in[bit_idx] |=> state == BOCD_FLUSH;
	endproperty
	a_one: assert property (p_one) else $error("skip on one missed");
	property p_stay_one;
		@(posedge clk_in) disable iff (!reset_n_in)
		run && test_skip_if_one_op && !file_rdata_in[bit_idx] |=> !busy_out;
	endproperty
	a_stay_one: assert property (p_stay_one) else $error("skip on one taken wrongly");
	property p_addr;
		@(posedge clk_in) disable iff (!reset_n_in)
		run |-> file_addr_out == instr_in[FADDR_W-1:0];
	endproperty
	a_addr: assert property (p_addr) else $error("file address field wrong");
	property p_push;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_call_taken |=> stack_push_out && stack_top_out == $past(pc) + 13'h0001;
	endproperty
	a_push: assert property (p_push) else $error("return address wrong");
	property p_push_once;
		@(posedge clk_in) disable iff (!reset_n_in)
		stack_push_out |=> !stack_push_out;
	endproperty
	a_push_once: assert property (p_push_once) else $error("push longer than one cycle");
	property p_target;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_call_taken |=> pc_out == {$past(pc_high_latch_in[LATCH_HI:LATCH_LO]),
			$past(instr_in[CALL_K_W-1:0])};
	endproperty
	a_target: assert property (p_target) else $error("call target wrong");
	property p_call2;
		@(posedge clk_in) disable iff (!reset_n_in)
		s_call_taken |=> s_one_nop;
	endproperty
	a_call2: assert property (p_call2) else $error("call not two cycles");
	property p_call_hold;
		@(posedge clk_in) disable iff (!reset_n_in)
		state == BOCD_CALL2 |=> pc_out == $past(pc_out);
	endproperty
	a_call_hold: assert property (p_call_hold) else $error("call target not held");
	// a skip still steps the pc; only the call cycles break the count
	property p_step;
		@(posedge clk_in) disable iff (!reset_n_in)
		!call_op && state != BOCD_CALL2 |=> pc_out == $past(pc_out) + 13'h0001;
	endproperty
	a_step: assert property (p_step) else $error("pc step wrong");
	property p_status;
		@(posedge clk_in) disable iff (!reset_n_in)
		file_we_out |-> !status_we_out && run;
	endproperty
	a_status: assert property (p_status) else $error("status touched");
	// no disable here: this one watches the reset itself
	property p_reset_quiet;
		@(posedge clk_in)
		!reset_n_in |-> !file_we_out ##1 (pc_out == PC_RESET && !stack_push_out && !busy_out);
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("reset not clean");
endmodule

// >>> tb/tb_bocd_core.sv
// tb_bocd_core: directed bench for the bit clear/set, bit test skip and call decoder
// assumes the fetch side is played here: one word per cycle, driven on the falling edge
`timescale 1ns/100ps
module tb_bocd_core
	import bocd_pkg::*;
;
	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic [OPW-1:0] instr_in = NOP_WORD;
	logic [7:0] file_rdata_in = 8'h00;
	logic [7:0] pc_high_latch_in = 8'h00;
	logic [FADDR_W-1:0] file_addr_out;
	logic [7:0] file_wdata_out;
	logic file_we_out, stack_push_out, status_we_out, busy_out;
	logic [PCW-1:0] pc_out, stack_top_out;
	int bad_count = 0;
	int n_checks = 0;
	bocd_core bocd_core_i (.clk_in, .reset_n_in, .instr_in, .file_rdata_in,
		.pc_high_latch_in, .file_addr_out, .file_wdata_out, .file_we_out, .pc_out,
		.stack_push_out, .stack_top_out, .status_we_out, .busy_out);
	always #20 clk_in = ~clk_in;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task print_verdict;
		if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one word per cycle; the short delay lets combinational outputs settle
	task drive(input logic [OPW-1:0] op, input logic [7:0] rd);
		@(negedge clk_in);
		instr_in = op;
		file_rdata_in = rd;
		#1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task do_reset;
		@(negedge clk_in);
		reset_n_in = 1'b0;
		instr_in = 14'h1780;
		repeat (12) @(negedge clk_in);
		chk(16'(pc_out), 16'h0000);
		chk(16'(stack_top_out), 16'h0000);
		chk(16'(busy_out), 16'h0000);
		chk(16'(file_we_out), 16'h0000);
		reset_n_in = 1'b1;
		instr_in = NOP_WORD;
	endtask
	task bit_ops;
		logic [PCW-1:0] p;
		drive(14'h13ff, 8'hc7);
		p = pc_out;
		chk(16'(file_we_out), 16'h0001);
		chk(16'(file_addr_out), 16'h007f);
		chk(16'(file_wdata_out), 16'h0047);
		chk(16'(status_we_out), 16'h0000);
		drive(14'h1780, 8'h0a);
		chk(16'(pc_out), 16'(p + 13'h0001));
		chk(16'(file_we_out), 16'h0001);
		chk(16'(file_addr_out), 16'h0000);
		chk(16'(file_wdata_out), 16'h008a);
	endtask
	// a bit set follows the test; it must vanish when the skip is taken
	task skip(input logic [OPW-1:0] op, input logic [7:0] rd, input logic take);
		logic [PCW-1:0] p;
		drive(op, rd);
		p = pc_out;
		chk(16'(file_we_out), 16'h0000);
		drive(14'h1780, 8'h00);
		chk(16'(busy_out), 16'(take));
		chk(16'(file_we_out), 16'(!take));
		drive(NOP_WORD, 8'h00);
		chk(16'(busy_out), 16'h0000);
		chk(16'(pc_out), 16'(p + 13'h0002));
	endtask
	task call_op(input logic [10:0] k, input logic [7:0] lat);
		logic [PCW-1:0] p;
		@(negedge clk_in);
		instr_in = {OP_CALL, k};
		file_rdata_in = 8'h00;
		pc_high_latch_in = lat;
		#1;
		p = pc_out;
		drive(14'h1780, 8'h00);
		chk(16'(stack_push_out), 16'h0001);
		chk(16'(stack_top_out), 16'(p + 13'h0001));
		chk(16'(pc_out), 16'({lat[4:3], k}));
		chk(16'(busy_out), 16'h0001);
		chk(16'(file_we_out), 16'h0000);
		drive(NOP_WORD, 8'h00);
		chk(16'(busy_out), 16'h0000);
		chk(16'(pc_out), 16'({lat[4:3], k}));
		chk(16'(stack_push_out), 16'h0000);
		chk(16'(stack_top_out), 16'(p + 13'h0001));
	endtask
	// ----------------------------------------
	// main sequence and hang guard
	// ----------------------------------------
	initial begin
		do_reset;
		bit_ops;
		skip(14'h1885, 8'hfd, 1'b1);
		skip(14'h1885, 8'h02, 1'b0);
		skip(14'h1c85, 8'h02, 1'b1);
		skip(14'h1c85, 8'hfd, 1'b0);
		call_op(11'h7ff, 8'h10);
		call_op(11'h000, 8'hef);
		do_reset;
		bit_ops;
		print_verdict;
	end
	initial begin
		#100000;
		bad_count++;
		print_verdict;
	end
endmodule
